// *** network_indicator_frame_builder_tb_top.sv ***
`timescale 1ns/1ps
module network_indicator_frame_builder_tb_top;
    import nifb_pkg::*;
    localparam int MH = 4;

    logic            CLK = 1'b0, RST = 1'b1, OTA_REQ = 1'b0, RR_REQ = 1'b0, stall = 1'b0;
    logic            OTA_BCAST = 1'b0, OTA_BLK_VALID = 1'b0, RR_BCAST = 1'b0;
    logic [63:0]     OTA_SRC64 = '0, OTA_TGT64 = '0, RR_SRC64 = '0;
    logic [15:0]     OTA_UPD16 = '0, RR_SRC16 = '0;
    logic [7:0]      OTA_BLK = '0, RR_NHOPS = '0, OUT_DATA;
    logic [16*MH-1:0] RR_HOPS = '0;
    nifb_msg_t       OTA_MSG = NIFB_MSG_ACK;
    logic            OUT_VALID, OUT_LAST, OUT_READY, BUSY, host_ok;
    int              err_count = 0, cmp_count = 0, nframes = 0, n0, i, m, c;
    int              hl[4] = '{0, 3, MH, 255};
    logic [7:0]      got[$], exp[$];
    logic [7:0]      codes[5] = '{NIFB_MT_ACK, NIFB_MT_NACK, NIFB_MT_NOMAC, NIFB_MT_QUERY,
                                  NIFB_MT_QRESP};

    always #2 CLK = ~CLK;

    nifb_frame_builder #(.MAX_HOPS(MH)) i_dut (
        .CLK(CLK), .RST(RST), .OTA_REQ(OTA_REQ), .OTA_SRC64(OTA_SRC64),
        .OTA_UPD16(OTA_UPD16), .OTA_BCAST(OTA_BCAST), .OTA_MSG(OTA_MSG),
        .OTA_BLK_VALID(OTA_BLK_VALID), .OTA_BLK(OTA_BLK), .OTA_TGT64(OTA_TGT64),
        .RR_REQ(RR_REQ), .RR_SRC64(RR_SRC64), .RR_SRC16(RR_SRC16), .RR_BCAST(RR_BCAST),
        .RR_NHOPS(RR_NHOPS), .RR_HOPS(RR_HOPS), .OUT_DATA(OUT_DATA), .OUT_VALID(OUT_VALID),
        .OUT_LAST(OUT_LAST), .OUT_READY(OUT_READY), .BUSY(BUSY));

    nifb_host_model i_host (
        .clk(CLK), .rst(RST), .data(OUT_DATA), .valid(OUT_VALID), .last(OUT_LAST),
        .ready(OUT_READY), .stall(stall), .frame_ok(host_ok));

    // both handshake sides are registered, so mid-cycle shows what the next edge takes
    always @(negedge CLK) begin
        if (OUT_VALID === 1'b1 && OUT_READY === 1'b1) begin
            got.push_back(OUT_DATA);
            if (OUT_LAST === 1'b1) nframes++;
        end
    end

    task automatic chk(input bit ok, input string msg);
        cmp_count++;
        if (!ok) begin
            err_count++;
            $display("ERROR %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic put(input logic [7:0] b);
        exp.push_back(b);
    endtask : put

    task automatic put64(input logic [63:0] v);
        for (int k = 7; k >= 0; k--) put(v[8*k+:8]);
    endtask : put64

    // header, then fields are appended by the caller
    task automatic hdr(input logic [15:0] len, input logic [7:0] ty);
        exp.delete();
        put(NIFB_DELIM);
        put(len[15:8]);
        put(len[7:0]);
        put(ty);
    endtask : hdr

    task automatic seal();
        logic [7:0] s;
        s = 8'h00;
        for (int k = 3; k < exp.size(); k++) s = s + exp[k];
        put(NIFB_CKS_BASE - s);
    endtask : seal

    // one request, a refused one while busy, then compare the whole frame
    task automatic run(input bit ota, input bit rr);
        got.delete();
        n0 = nframes;
        @(negedge CLK);
        OTA_REQ = ota;
        RR_REQ  = rr;
        @(negedge CLK);
        OTA_REQ = 1'b0;
        RR_REQ  = 1'b0;
        @(negedge CLK);
        chk(BUSY === 1'b1, "busy not raised after request");
        RR_REQ = 1'b1;
        @(negedge CLK);
        RR_REQ = 1'b0;
        for (int k = 0; k < 2000 && nframes == n0; k++) @(negedge CLK);
        repeat (8) @(negedge CLK);
        chk(got.size() == exp.size(), "frame length wrong or extra frame");
        for (int k = 0; k < exp.size() && k < got.size(); k++)
            chk(got[k] === exp[k], $sformatf("byte %0d got %h exp %h", k, got[k], exp[k]));
        chk(host_ok === 1'b1, "host rejected checksum");
        chk(BUSY === 1'b0, "busy stuck after frame");
    endtask : run

    task automatic wrap_up();
        $display("errors %0d comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    initial begin
        // nine frames with stalls need well under a thousand cycles
        #100000;
        err_count++;
        $display("ERROR %0t: watchdog expired", $time);
        wrap_up();
    end

    initial begin
        void'($urandom(32'hb34e));
        repeat (20) @(negedge CLK);
        RST = 1'b0;
        // every message code, block number present and absent
        for (m = 0; m < 5; m++) begin
            stall         = m[0];
            // message codes are driven in enum order: ack, nack, nomac, query, qresp
            OTA_MSG       = nifb_msg_t'(m);
            OTA_SRC64     = {$urandom, $urandom};
            OTA_TGT64     = {$urandom, $urandom};
            OTA_UPD16     = 16'($urandom);
            OTA_BLK       = 8'($urandom);
            OTA_BLK_VALID = m[1];
            OTA_BCAST     = m[0];
            hdr(NIFB_LEN_OTA, NIFB_TYPE_OTA);
            put64(OTA_SRC64);
            put(OTA_UPD16[15:8]);
            put(OTA_UPD16[7:0]);
            put(OTA_BCAST ? NIFB_RXO_BCAST : NIFB_RXO_ACKED);
            put(codes[m]);
            put(OTA_BLK_VALID ? OTA_BLK : 8'h00);
            put64(OTA_TGT64);
            seal();
            run(1'b1, m == 4);
        end
        // hop counts: none, some, full, clamped
        for (m = 0; m < 4; m++) begin
            stall     = ~m[0];
            RR_NHOPS  = 8'(hl[m]);
            RR_SRC64  = {$urandom, $urandom};
            RR_SRC16  = 16'($urandom);
            RR_BCAST  = m[1];
            RR_HOPS   = {$urandom, $urandom};
            c         = (hl[m] > MH) ? MH : hl[m];
            hdr(16'(NIFB_LEN_RR_BASE + 2 * c), NIFB_TYPE_RR);
            put64(RR_SRC64);
            put(RR_SRC16[15:8]);
            put(RR_SRC16[7:0]);
            put(RR_BCAST ? NIFB_RXO_BCAST : NIFB_RXO_ACKED);
            put(8'(c));
            for (i = 0; i < c; i++) begin
                put(RR_HOPS[16*i+8+:8]);
                put(RR_HOPS[16*i+:8]);
            end
            seal();
            run(1'b0, 1'b1);
        end
        wrap_up();
    end
endmodule : network_indicator_frame_builder_tb_top

// *** nifb_cksum.sv ***
`timescale 1ns/1ps
module nifb_cksum (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // byte feed
    input  wire logic       clr,
    input  wire logic       add,
    input  wire logic [7:0] data,
    // result
    output logic      [7:0] cks
);
    import nifb_pkg::*;

    logic [7:0] sum_q;
    logic [7:0] sum_d;

    always_comb begin
        sum_d = sum_q;
        if (clr) begin
            sum_d = 8'h00;
        end else if (add) begin
            sum_d = 8'(sum_q + data);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sum_q <= 8'h00;
        end else begin
            sum_q <= sum_d;
        end
    end

    // shown combinationally so the builder loads it without a bubble
    assign cks = NIFB_CKS_BASE - sum_q;

endmodule : nifb_cksum

// *** nifb_frame_builder.sv ***
`timescale 1ns/1ps
// Function
// - An update status frame carries type code 0xa0 in byte 3.
// - Update status bytes 4 to 11 hold the responding radio's 64-bit address, high byte first.
// - Update status bytes 12 and 13 hold the updater's 16-bit network address.
// - Byte 14 is 0x01 for an acknowledged packet and 0x02 for a broadcast.
// - Byte 15 holds the bootloader message code 0x06, 0x15, 0x40, 0x51 or 0x52.
// - Byte 16 repeats the block number, or zero where none applies.
// - From byte 17 the target's 64-bit address follows, high byte first.
// - A query that met an inactive bootloader is reported with code 0x51.
// - A route record event taken while idle, with no update status request in the same cycle, yields a frame with type code 0xa1 in byte 3.
// - Route record bytes 4 to 11 hold the originator's 64-bit address, high byte first.
// - Route record bytes 12 and 13 hold the originator's 16-bit address and byte 14 the receive options.
// - Route record byte 15 counts the intermediate hops, source and destination excluded.
// - From byte 16 each hop follows as two bytes, destination's neighbour first.
module nifb_frame_builder #(
    parameter int MAX_HOPS = 8
) (
    // clock and reset
    input  wire logic                       CLK,
    input  wire logic                       RST,
    // update status event
    input  wire logic                       OTA_REQ,
    input  wire logic [63:0]                OTA_SRC64,
    input  wire logic [15:0]                OTA_UPD16,
    input  wire logic                       OTA_BCAST,
    input  wire nifb_pkg::nifb_msg_t        OTA_MSG,
    input  wire logic                       OTA_BLK_VALID,
    input  wire logic [7:0]                 OTA_BLK,
    input  wire logic [63:0]                OTA_TGT64,
    // route record event
    input  wire logic                       RR_REQ,
    input  wire logic [63:0]                RR_SRC64,
    input  wire logic [15:0]                RR_SRC16,
    input  wire logic                       RR_BCAST,
    input  wire logic [7:0]                 RR_NHOPS,
    input  wire logic [16*MAX_HOPS-1:0]     RR_HOPS,
    // serial byte stream
    output logic      [7:0]                 OUT_DATA,
    output logic                            OUT_VALID,
    output logic                            OUT_LAST,
    input  wire logic                       OUT_READY,
    // status
    output logic                            BUSY
);
    import nifb_pkg::*;

    logic        busy_q,  busy_d;
    logic        rr_q,    rr_d;
    logic [7:0]  idx_q,   idx_d;
    logic [7:0]  pos_q,   pos_d;
    logic [7:0]  data_q,  data_d;
    logic        valid_q, valid_d;
    logic        last_q,  last_d;
    logic        bsy_o_q, bsy_o_d;
    logic [63:0] src_q,   src_d;
    logic [15:0] a16_q,   a16_d;
    logic [7:0]  rxo_q,   rxo_d;
    logic [7:0]  msg_q,   msg_d;
    logic [7:0]  blk_q,   blk_d;
    logic [63:0] tgt_q,   tgt_d;
    logic [7:0]  nhop_q,  nhop_d;
    logic [15:0] hops_q [MAX_HOPS];
    logic [15:0] hops_d [MAX_HOPS];

    logic [15:0] len;
    logic [7:0]  last_idx;
    logic [7:0]  body;
    logic [7:0]  cks;
    logic        cks_clr;
    logic        cks_add;
    logic        take;

    function automatic logic [7:0] msg_code(input nifb_msg_t m);
        unique case (m)
            NIFB_MSG_ACK:   msg_code = NIFB_MT_ACK;
            NIFB_MSG_NACK:  msg_code = NIFB_MT_NACK;
            NIFB_MSG_NOMAC: msg_code = NIFB_MT_NOMAC;
            NIFB_MSG_QUERY: msg_code = NIFB_MT_QUERY;
            NIFB_MSG_QRESP: msg_code = NIFB_MT_QRESP;
            default:        msg_code = NIFB_MT_ACK;
        endcase
    endfunction : msg_code

    nifb_cksum u_cksum (
        .clk  (CLK),
        .rst  (RST),
        .clr  (cks_clr),
        .add  (cks_add),
        .data (data_d),
        .cks  (cks)
    );

    // frame length and the byte at the next load index
    always_comb begin
        automatic int i = 0;
        automatic int k = 0;
        len      = rr_q ? 16'(NIFB_LEN_RR_BASE + {nhop_q, 1'b0}) : NIFB_LEN_OTA;
        last_idx = 8'(len + 16'd3);
        i        = int'(idx_q);
        k        = (i - NIFB_OFS_HOP) >> 1;
        if (i == 0) begin
            body = NIFB_DELIM;
        end else if (i == NIFB_OFS_LEN_HI) begin
            body = len[15:8];
        end else if (i == NIFB_OFS_LEN_LO) begin
            body = len[7:0];
        end else if (i == NIFB_OFS_TYPE) begin
            body = rr_q ? NIFB_TYPE_RR : NIFB_TYPE_OTA;
        end else if (i <= NIFB_OFS_SRC64E) begin
            body = src_q[8*(NIFB_OFS_SRC64E-i) +: 8];
        end else if (i == NIFB_OFS_A16_HI) begin
            body = a16_q[15:8];
        end else if (i == NIFB_OFS_A16_LO) begin
            body = a16_q[7:0];
        end else if (i == NIFB_OFS_RXO) begin
            body = rxo_q;
        end else if (i == NIFB_OFS_MSG) begin
            body = rr_q ? nhop_q : msg_q;
        end else if (rr_q) begin
            // even offsets carry the high byte of a hop
            body = i[0] ? hops_q[k][7:0] : hops_q[k][15:8];
        end else if (i == NIFB_OFS_BLK) begin
            body = blk_q;
        end else begin
            body = tgt_q[8*(NIFB_OFS_TGTE-i) +: 8];
        end
    end

    always_comb begin
        busy_d  = busy_q;
        rr_d    = rr_q;
        idx_d   = idx_q;
        pos_d   = pos_q;
        data_d  = data_q;
        valid_d = valid_q;
        last_d  = last_q;
        src_d   = src_q;
        a16_d   = a16_q;
        rxo_d   = rxo_q;
        msg_d   = msg_q;
        blk_d   = blk_q;
        tgt_d   = tgt_q;
        nhop_d  = nhop_q;
        hops_d  = hops_q;
        cks_clr = 1'b0;
        cks_add = 1'b0;
        take    = !valid_q || OUT_READY;
        if (take) begin
            valid_d = 1'b0;
            last_d  = 1'b0;
        end
        // a new event is ignored until the last byte has left; update status wins a tie
        if (!bsy_o_q && OTA_REQ) begin
            busy_d  = 1'b1;
            rr_d    = 1'b0;
            idx_d   = 8'h00;
            cks_clr = 1'b1;
            src_d   = OTA_SRC64;
            a16_d   = OTA_UPD16;
            rxo_d   = OTA_BCAST ? NIFB_RXO_BCAST : NIFB_RXO_ACKED;
            msg_d   = msg_code(OTA_MSG);
            blk_d   = OTA_BLK_VALID ? OTA_BLK : 8'h00;
            tgt_d   = OTA_TGT64;
        end else if (!bsy_o_q && RR_REQ) begin
            busy_d  = 1'b1;
            rr_d    = 1'b1;
            idx_d   = 8'h00;
            cks_clr = 1'b1;
            src_d   = RR_SRC64;
            a16_d   = RR_SRC16;
            rxo_d   = RR_BCAST ? NIFB_RXO_BCAST : NIFB_RXO_ACKED;
            // more hops than storage are cut, not wrapped
            nhop_d  = (RR_NHOPS > 8'(MAX_HOPS)) ? 8'(MAX_HOPS) : RR_NHOPS;
            for (int h = 0; h < MAX_HOPS; h++) begin
                hops_d[h] = RR_HOPS[16*h +: 16];
            end
        end else if (busy_q && take) begin
            valid_d = 1'b1;
            pos_d   = idx_q;
            idx_d   = idx_q + 8'h01;
            last_d  = (idx_q == last_idx);
            data_d  = (idx_q == last_idx) ? cks : body;
            cks_add = (idx_q >= 8'(NIFB_OFS_TYPE)) && (idx_q < last_idx);
            if (idx_q == last_idx) begin
                busy_d = 1'b0;
            end
        end
        bsy_o_d = busy_d || valid_d;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            busy_q  <= 1'b0;
            rr_q    <= 1'b0;
            idx_q   <= 8'h00;
            pos_q   <= 8'h00;
            data_q  <= 8'h00;
            valid_q <= 1'b0;
            last_q  <= 1'b0;
            bsy_o_q <= 1'b0;
            src_q   <= 64'h0;
            a16_q   <= 16'h0;
            rxo_q   <= 8'h00;
            msg_q   <= 8'h00;
            blk_q   <= 8'h00;
            tgt_q   <= 64'h0;
            nhop_q  <= 8'h00;
        end else begin
            busy_q  <= busy_d;
            rr_q    <= rr_d;
            idx_q   <= idx_d;
            pos_q   <= pos_d;
            data_q  <= data_d;
            valid_q <= valid_d;
            last_q  <= last_d;
            bsy_o_q <= bsy_o_d;
            src_q   <= src_d;
            a16_q   <= a16_d;
            rxo_q   <= rxo_d;
            msg_q   <= msg_d;
            blk_q   <= blk_d;
            tgt_q   <= tgt_d;
            nhop_q  <= nhop_d;
        end
        hops_q <= hops_d;
    end

    assign OUT_DATA  = data_q;
    assign OUT_VALID = valid_q;
    assign OUT_LAST  = last_q;
    assign BUSY      = bsy_o_q;

    // independent running sum for the checksum check
    logic [7:0] chk_sum_q;
    always_ff @(posedge CLK) begin
        if (RST) begin
            chk_sum_q <= 8'h00;
        end else if (valid_q && OUT_READY) begin
            chk_sum_q <= last_q ? 8'h00 : ((pos_q >= 8'd3) ? 8'(chk_sum_q + data_q) : 8'h00);
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    chk_ota_type: assert property (
        valid_q && !rr_q && pos_q == 8'd3 |-> data_q == 8'ha0)
        else $error("update status type byte wrong");
    chk_src_order: assert property (
        valid_q && !last_q && pos_q == 8'd4 |-> data_q == src_q[63:56])
        else $error("source address not high byte first");
    chk_upd_addr: assert property (
        valid_q && !rr_q && pos_q == 8'd13 |-> data_q == a16_q[7:0])
        else $error("updater address low byte wrong");
    chk_rx_opts: assert property (
        valid_q && pos_q == 8'd14 |-> data_q == 8'h01 || data_q == 8'h02)
        else $error("receive options out of range");
    chk_msg_code: assert property (
        valid_q && !rr_q && pos_q == 8'd15 |->
            data_q inside {8'h06, 8'h15, 8'h40, 8'h51, 8'h52})
        else $error("bootloader message code illegal");
    chk_query_code: assert property (
        OTA_REQ && !BUSY && OTA_MSG == NIFB_MSG_QUERY |=> msg_q == 8'h51)
        else $error("inactive bootloader query not coded 0x51");
    chk_blk_zero: assert property (
        OTA_REQ && !BUSY && !OTA_BLK_VALID |=> blk_q == 8'h00)
        else $error("block number not zero when absent");
    chk_tgt_last: assert property (
        valid_q && !rr_q && pos_q == 8'd24 |-> data_q == tgt_q[7:0])
        else $error("target address low byte wrong");
    chk_rr_type: assert property (
        valid_q && rr_q && pos_q == 8'd3 |-> data_q == 8'ha1)
        else $error("route record type byte wrong");
    chk_rr_src: assert property (
        valid_q && rr_q && pos_q == 8'd11 |-> data_q == src_q[7:0])
        else $error("route record source low byte wrong");
    chk_rr_count: assert property (
        valid_q && rr_q && pos_q == 8'd15 |-> data_q == nhop_q)
        else $error("hop count byte wrong");
    chk_rr_hop: assert property (
        valid_q && rr_q && !last_q && pos_q == 8'd16 |-> data_q == hops_q[0][15:8])
        else $error("first hop not destination neighbour high byte");
    // length high byte is zero for any hop storage below 121 entries
    chk_delim_len: assert property (
        valid_q && pos_q <= 8'd2 |->
            data_q == ((pos_q == 8'd0) ? 8'h7e : (pos_q == 8'd1) ? 8'h00 :
                       rr_q ? 8'(8'd13 + {nhop_q[6:0], 1'b0}) : 8'h16))
        else $error("frame does not open with delimiter and length");
    chk_cksum_val: assert property (
        valid_q && last_q |-> 8'(data_q + chk_sum_q) == 8'hff)
        else $error("checksum byte wrong");
    chk_out_hold: assert property (
        valid_q && !OUT_READY |=> valid_q && $stable(data_q) && $stable(last_q))
        else $error("output byte changed while stalled");

    cov_ota_done:  cover property (valid_q && OUT_READY && last_q && !rr_q);
    cov_rr_done:   cover property (valid_q && OUT_READY && last_q && rr_q && nhop_q == 8'd3);
    cov_stall:     cover property (valid_q && !OUT_READY [*3]);
    cov_both_req:  cover property (OTA_REQ && RR_REQ && !BUSY);

endmodule : nifb_frame_builder

// *** nifb_host_model.sv ***
`timescale 1ns/1ps
module nifb_host_model
    import nifb_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // byte stream from the builder
    input  wire logic [7:0] data,
    input  wire logic       valid,
    input  wire logic       last,
    output logic            ready,
    // test control
    input  wire logic       stall,
    // checksum verdict of the last frame
    output logic            frame_ok
);
    logic [7:0] sum_q;
    int         idx_q;

    // a stalling host drops ready at random, never for a fixed pattern
    always_ff @(posedge clk) begin
        if (rst) begin
            ready    <= 1'b0;
            sum_q    <= 8'h00;
            idx_q    <= 0;
            frame_ok <= 1'b0;
        end else begin
            ready <= stall ? 1'($urandom_range(1, 0)) : 1'b1;
            if (valid && ready) begin
                if (idx_q == 0) begin
                    frame_ok <= 1'b0;
                end
                if (last) begin
                    frame_ok <= ((sum_q + data) === NIFB_CKS_BASE);
                    idx_q    <= 0;
                    sum_q    <= 8'h00;
                end else begin
                    idx_q <= idx_q + 1;
                    if (idx_q >= 3) begin
                        sum_q <= sum_q + data;
                    end
                end
            end
        end
    end
endmodule : nifb_host_model

// *** nifb_pkg.sv ***
package nifb_pkg;

    // frame framing
    localparam logic [7:0]  NIFB_DELIM     = 8'h7e;
    localparam logic [7:0]  NIFB_TYPE_OTA  = 8'ha0;
    localparam logic [7:0]  NIFB_TYPE_RR   = 8'ha1;
    localparam logic [7:0]  NIFB_CKS_BASE  = 8'hff;

    // receive options encoding
    localparam logic [7:0]  NIFB_RXO_ACKED = 8'h01;
    localparam logic [7:0]  NIFB_RXO_BCAST = 8'h02;

    // bootloader message type codes
    localparam logic [7:0]  NIFB_MT_ACK    = 8'h06;
    localparam logic [7:0]  NIFB_MT_NACK   = 8'h15;
    localparam logic [7:0]  NIFB_MT_NOMAC  = 8'h40;
    localparam logic [7:0]  NIFB_MT_QUERY  = 8'h51;
    localparam logic [7:0]  NIFB_MT_QRESP  = 8'h52;

    // byte offsets inside a frame
    localparam int          NIFB_OFS_LEN_HI = 1;
    localparam int          NIFB_OFS_LEN_LO = 2;
    localparam int          NIFB_OFS_TYPE   = 3;
    localparam int          NIFB_OFS_SRC64  = 4;
    localparam int          NIFB_OFS_SRC64E = 11;
    localparam int          NIFB_OFS_A16_HI = 12;
    localparam int          NIFB_OFS_A16_LO = 13;
    localparam int          NIFB_OFS_RXO    = 14;
    localparam int          NIFB_OFS_MSG    = 15;
    localparam int          NIFB_OFS_NHOP   = 15;
    localparam int          NIFB_OFS_BLK    = 16;
    localparam int          NIFB_OFS_HOP    = 16;
    localparam int          NIFB_OFS_TGT    = 17;
    localparam int          NIFB_OFS_TGTE   = 24;

    // frame data lengths (type byte through last field)
    localparam logic [15:0] NIFB_LEN_OTA     = 16'h0016;
    localparam logic [15:0] NIFB_LEN_RR_BASE = 16'h000d;

    typedef enum logic [2:0] {
        NIFB_MSG_ACK,
        NIFB_MSG_NACK,
        NIFB_MSG_NOMAC,
        NIFB_MSG_QUERY,
        NIFB_MSG_QRESP
    } nifb_msg_t;

endpackage : nifb_pkg
